// ===== mcr_pkg.sv
// constants, types and helper functions of the modem configuration bank
package mcr_pkg;

   // ===========================================================
   // register offsets
   localparam logic [5:0] MCR_ADDR_BW_EXP    = 6'h10; // bandwidth_and_rate_exponent
   localparam logic [5:0] MCR_ADDR_RATE_MANT = 6'h11; // rate_mantissa
   localparam logic [5:0] MCR_ADDR_FMT_CTRL  = 6'h12; // modem_format_control

   // ===========================================================
   // values after reset
   localparam logic [7:0] MCR_RST_BW_EXP    = 8'h8C; // bw exp 2, bw mant 0, rate exp 12
   localparam logic [7:0] MCR_RST_RATE_MANT = 8'h22; // rate mantissa 34
   localparam logic [7:0] MCR_RST_FMT_CTRL  = 8'h02; // filter on, 2-level fsk, low bits 010
   localparam logic [7:0] MCR_RST_UNMAPPED  = 8'h00; // read answer of an unmapped offset

   // ===========================================================
   // field positions
   localparam int MCR_BWE_LSB  = 6; // bandwidth_exponent, bits 7:6
   localparam int MCR_BWM_LSB  = 4; // bandwidth_mantissa, bits 5:4
   localparam int MCR_SRE_LSB  = 0; // symbol_rate_exponent, bits 3:0
   localparam int MCR_DCB_BIT  = 7; // dc_block_bypass
   localparam int MCR_MODS_LSB = 4; // modulation_select, bits 6:4

   // ===========================================================
   // arithmetic constants
   localparam logic [8:0]  MCR_DECIM_BASE  = 9'h008;  // fixed factor of the decimation ratio
   localparam logic [8:0]  MCR_BWM_OFFSET  = 9'h004;  // added to the bandwidth mantissa
   localparam int          MCR_NCO_W       = 28;      // rate accumulator width, 2^28 divisor
   localparam int          MCR_STEP_W      = 24;      // widest rate step, 511 << 15
   localparam int          MCR_SAMPLE_W    = 12;      // adc sample width
   localparam int          MCR_DC_SHIFT    = 4;       // dc estimator time constant, 2^4 samples

   // ===========================================================
   // modulation codes and one-hot selection
   localparam logic [2:0] MCR_CODE_FSK2 = 3'h0;
   localparam logic [2:0] MCR_CODE_GFSK = 3'h1;
   localparam logic [2:0] MCR_CODE_ASK  = 3'h3;
   localparam logic [2:0] MCR_CODE_MSK  = 3'h7;

   typedef enum logic [4:0] {
      MCR_MOD_FSK2 = 5'h01,  // two-level fsk
      MCR_MOD_GFSK = 5'h02,  // gaussian fsk
      MCR_MOD_ASK  = 5'h04,  // amplitude / on-off keying
      MCR_MOD_MSK  = 5'h08,  // minimum shift keying
      MCR_MOD_NONE = 5'h10   // unassigned code
   } mcr_mod_t;

   // register access request
   typedef struct packed {
      logic       wr;     // write strobe
      logic       rd;     // read strobe
      logic [5:0] addr;   // register offset
      logic [7:0] wdata;  // write data
   } mcr_reg_req_t;

   // decimation ratio 8 * (4 + m) * 2^e
   function automatic logic [8:0] mcr_decim_ratio(input logic [1:0] e, input logic [1:0] m);
      logic [8:0] base;
      base = MCR_DECIM_BASE * (MCR_BWM_OFFSET + {7'h00, m});
      return base << e;
   endfunction : mcr_decim_ratio

   // rate step (256 + m) * 2^e, hidden one above the stored mantissa
   function automatic logic [MCR_STEP_W-1:0] mcr_rate_step(input logic [3:0] e,
                                                           input logic [7:0] m);
      logic [MCR_STEP_W-1:0] mant;
      mant = {15'h0000, 1'b1, m};
      return mant << e;
   endfunction : mcr_rate_step

endpackage : mcr_pkg

// ===== mcr_rate_nco.sv
// symbol-rate accumulator producing one strobe per symbol
`timescale 1ns/10ps
module mcr_rate_nco
   import mcr_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // rate configuration
   input  wire logic [3:0] rateExp,
   input  wire logic [7:0] rateMant,
   // symbol timing
   output logic            symbolStrobe
);

   // ===========================================================
   // step and accumulator
   logic [MCR_STEP_W-1:0] step;         // (256 + m) << e
   logic [MCR_NCO_W-1:0]  acc_reg;      // phase, wraps at 2^28
   logic [MCR_NCO_W:0]    acc_next;     // phase plus carry
   logic                  symbolStrobe_reg;

   // step with the hidden ninth mantissa bit
   assign step     = mcr_rate_step(rateExp, rateMant);
   assign acc_next = {1'b0, acc_reg} + {5'h00, step};

   // phase advances once per crystal cycle
   always_ff @(posedge mclk)
   begin
      if (rst)
         acc_reg <= '0;
      else
         acc_reg <= acc_next[MCR_NCO_W-1:0];
   end

   // carry out of bit 27 marks a symbol boundary
   always_ff @(posedge mclk)
   begin
      if (rst)
         symbolStrobe_reg <= 1'b0;
      else
         symbolStrobe_reg <= acc_next[MCR_NCO_W];
   end

   assign symbolStrobe = symbolStrobe_reg;

   // ===========================================================
   // checks
   // step must equal (256 + stored mantissa) scaled by the exponent
   chk_hidden_one: assert property (@(posedge mclk) disable iff (rst)
      step == ((24'h000100 + {16'h0000, rateMant}) << rateExp))
      else $error("rate step lacks the hidden mantissa one");

   chk_max_spacing: assert property (@(posedge mclk) disable iff (rst)
      (symbolStrobe && rateExp == 4'hF && rateMant == 8'hFF) |->
         ##[1:17] (symbolStrobe || rateExp != 4'hF || rateMant != 8'hFF))
      else $error("symbol strobes too far apart at fastest rate");

endmodule : mcr_rate_nco

// ===== mcr_modem_config.sv
// modem configuration registers with decimation, symbol timing and dc blocking
`timescale 1ns/10ps

module mcr_modem_config
   import mcr_pkg::*;
(
   // clock and reset
   input  wire logic                           mclk,
   input  wire logic                           rst,
   // register access
   input  wire mcr_reg_req_t                   regReq,
   output logic [7:0]                          regRdata,
   output logic                                regRvalid,
   // adc sample stream
   input  wire logic signed [MCR_SAMPLE_W-1:0] sampleIn,
   input  wire logic                           sampleValid,
   // filtered stream to the demodulator
   output logic signed [MCR_SAMPLE_W:0]        dcOut,
   output logic                                dcValid,
   // timing strobes
   output logic                                decimStrobe,
   output logic                                symbolStrobe,
   // modem mode
   output mcr_mod_t                            modulation,
   output logic                                dcBypass
);

   // ===========================================================
   // register storage
   logic [7:0] bwExp_reg;      // bandwidth_and_rate_exponent
   logic [7:0] rateMant_reg;   // rate_mantissa
   logic [7:0] fmtCtrl_reg;    // modem_format_control
   logic [7:0] regRdata_reg;   // read answer
   logic       regRvalid_reg;  // read answer valid

   // field views
   logic [1:0] bandwidthExponent;
   logic [1:0] bandwidthMantissa;
   logic [3:0] symbolRateExponent;
   logic [2:0] modulationSelect;
   logic       dcBlockBypass;

   assign bandwidthExponent  = bwExp_reg[MCR_BWE_LSB +: 2];
   assign bandwidthMantissa  = bwExp_reg[MCR_BWM_LSB +: 2];
   assign symbolRateExponent = bwExp_reg[MCR_SRE_LSB +: 4];
   assign modulationSelect   = fmtCtrl_reg[MCR_MODS_LSB +: 3];
   assign dcBlockBypass      = fmtCtrl_reg[MCR_DCB_BIT];

   // write to bandwidth and exponent register
   always_ff @(posedge mclk)
   begin
      if (rst)
         bwExp_reg <= MCR_RST_BW_EXP;
      else if (regReq.wr && regReq.addr == MCR_ADDR_BW_EXP)
         bwExp_reg <= regReq.wdata;
   end

   // write to rate mantissa register
   always_ff @(posedge mclk)
   begin
      if (rst)
         rateMant_reg <= MCR_RST_RATE_MANT;
      else if (regReq.wr && regReq.addr == MCR_ADDR_RATE_MANT)
         rateMant_reg <= regReq.wdata;
   end

   // write to format control register; low nibble is plain storage here
   always_ff @(posedge mclk)
   begin
      if (rst)
         fmtCtrl_reg <= MCR_RST_FMT_CTRL;
      else if (regReq.wr && regReq.addr == MCR_ADDR_FMT_CTRL)
         fmtCtrl_reg <= regReq.wdata;
   end

   // read answer one cycle after the strobe
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         regRdata_reg  <= MCR_RST_UNMAPPED;
         regRvalid_reg <= 1'b0;
      end
      else
      begin
         regRvalid_reg <= regReq.rd;
         if (regReq.rd)
         begin
            if (regReq.addr == MCR_ADDR_BW_EXP)
               regRdata_reg <= bwExp_reg;
            else if (regReq.addr == MCR_ADDR_RATE_MANT)
               regRdata_reg <= rateMant_reg;
            else if (regReq.addr == MCR_ADDR_FMT_CTRL)
               regRdata_reg <= fmtCtrl_reg;
            else
               regRdata_reg <= MCR_RST_UNMAPPED; // unmapped offset
         end
      end
   end

   // ===========================================================
   // channel filter decimation
   logic [8:0] decimRatio;   // mclk cycles per decimation strobe
   logic [8:0] decimCnt_reg; // counts down to the next output
   logic       decimStrobe_reg;

   assign decimRatio = mcr_decim_ratio(bandwidthExponent, bandwidthMantissa);

   // reload on zero so a new ratio applies from the next period
   always_ff @(posedge mclk)
   begin
      if (rst)
         decimCnt_reg <= '0;
      else if (decimCnt_reg == 9'h000)
         decimCnt_reg <= decimRatio - 9'h001;
      else
         decimCnt_reg <= decimCnt_reg - 9'h001;
   end

   // one-cycle strobe per decimated sample
   always_ff @(posedge mclk)
   begin
      if (rst)
         decimStrobe_reg <= 1'b0;
      else
         decimStrobe_reg <= (decimCnt_reg == 9'h000);
   end

   // ===========================================================
   // symbol timing
   mcr_rate_nco u_rate_nco (
      .mclk         (mclk),
      .rst          (rst),
      .rateExp      (symbolRateExponent),
      .rateMant     (rateMant_reg),
      .symbolStrobe (symbolStrobe)
   );

   // ===========================================================
   // dc blocking filter
   logic signed [MCR_SAMPLE_W+MCR_DC_SHIFT-1:0] dcAcc_reg; // dc estimate, scaled up
   logic signed [MCR_SAMPLE_W-1:0]              dcEst;     // dc estimate
   logic signed [MCR_SAMPLE_W:0]                dcOut_reg;
   logic                                        dcValid_reg;
   logic                                        dcBypass_reg;

   assign dcEst = dcAcc_reg[MCR_SAMPLE_W+MCR_DC_SHIFT-1:MCR_DC_SHIFT];

   // leaky estimate of the mean, frozen while bypassed to save switching
   always_ff @(posedge mclk)
   begin
      if (rst)
         dcAcc_reg <= '0;
      else if (sampleValid && !dcBlockBypass)
         dcAcc_reg <= dcAcc_reg + 16'(sampleIn) - 16'(dcEst);
   end

   // filtered or passed-through sample
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         dcOut_reg   <= '0;
         dcValid_reg <= 1'b0;
      end
      else
      begin
         dcValid_reg <= sampleValid;
         if (sampleValid)
         begin
            if (dcBlockBypass)
               dcOut_reg <= 13'(sampleIn);
            else
               dcOut_reg <= 13'(sampleIn) - 13'(dcEst);
         end
      end
   end

   // bypass flag for the analog side; host keeps it for low rates only
   always_ff @(posedge mclk)
   begin
      if (rst)
         dcBypass_reg <= 1'b0;
      else
         dcBypass_reg <= dcBlockBypass;
   end

   // ===========================================================
   // modulation decode
   mcr_mod_t modulation_reg;

   always_ff @(posedge mclk)
   begin
      if (rst)
         modulation_reg <= MCR_MOD_FSK2;
      else
      begin
         case (modulationSelect)
            MCR_CODE_FSK2: modulation_reg <= MCR_MOD_FSK2;
            MCR_CODE_GFSK: modulation_reg <= MCR_MOD_GFSK;
            MCR_CODE_ASK:  modulation_reg <= MCR_MOD_ASK;
            MCR_CODE_MSK:  modulation_reg <= MCR_MOD_MSK;
            default:       modulation_reg <= MCR_MOD_NONE; // unassigned code
         endcase
      end
   end

   // outputs from flops
   assign regRdata    = regRdata_reg;
   assign regRvalid   = regRvalid_reg;
   assign dcOut       = dcOut_reg;
   assign dcValid     = dcValid_reg;
   assign decimStrobe = decimStrobe_reg;
   assign modulation  = modulation_reg;
   assign dcBypass    = dcBypass_reg;

   // ===========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // spacing helper: cycles since last strobe, primed when config is steady
   logic [8:0] gap_reg;
   logic       primed_reg;
   logic       wrPrev_reg;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         gap_reg    <= '0;
         primed_reg <= 1'b0;
         wrPrev_reg <= 1'b0;
      end
      else
      begin
         wrPrev_reg <= regReq.wr;
         gap_reg    <= decimStrobe_reg ? 9'h001 : gap_reg + 9'h001;
         if (regReq.wr || wrPrev_reg)
            primed_reg <= 1'b0;
         else if (decimStrobe_reg)
            primed_reg <= 1'b1;
      end
   end

   sequence s_exp_write;
      regReq.wr && regReq.addr == MCR_ADDR_BW_EXP;
   endsequence

   sequence s_sample_bypassed;
      sampleValid && dcBlockBypass;
   endsequence

   chk_decim_spacing: assert property (
      (decimStrobe && primed_reg && !regReq.wr && !wrPrev_reg) |-> gap_reg == decimRatio)
      else $error("decimation strobe spacing differs from ratio");

   chk_exp_field: assert property (
      s_exp_write |=> symbolRateExponent == $past(regReq.wdata[3:0]))
      else $error("symbol rate exponent not taken from low nibble");

   chk_dc_bypass: assert property (
      s_sample_bypassed |=> dcValid && dcOut == 13'($past(sampleIn)))
      else $error("bypassed sample altered");

   chk_dc_active: assert property (
      (sampleValid && !dcBlockBypass) |=>
         dcOut == 13'($past(sampleIn)) - 13'($past(dcEst)))
      else $error("dc estimate not removed");

   chk_mod_ask: assert property (
      (modulationSelect == MCR_CODE_ASK) |=> modulation == MCR_MOD_ASK)
      else $error("ask code not decoded");

   chk_mod_unassigned: assert property (
      (modulationSelect == 3'h2) |=> modulation == MCR_MOD_NONE)
      else $error("unassigned code decoded as a format");

endmodule : mcr_modem_config

// ===== mcr_modem_config_bench.sv
// self-checking bench of the modem configuration bank
`timescale 1ns/10ps

`define CHK(got, exp) \
   begin \
      nChecks++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module mcr_modem_config_bench
   import mcr_pkg::*;
;
   // ==========================================================
   // stimulus and observed signals
   logic                           mclk;          // 125 MHz clock
   logic                           rst;           // synchronous reset
   mcr_reg_req_t                   regReq;        // register request
   logic [7:0]                     regRdata;      // read answer
   logic                           regRvalid;     // read answer strobe
   logic signed [MCR_SAMPLE_W-1:0] sampleIn;      // adc sample
   logic                           sampleValid;   // sample qualifier
   logic signed [MCR_SAMPLE_W:0]   dcOut;         // filtered sample
   logic                           dcValid;       // filtered sample strobe
   logic                           decimStrobe;   // decimation strobe
   logic                           symbolStrobe;  // symbol strobe
   mcr_mod_t                       modulation;    // one-hot modulation
   logic                           dcBypass;      // filter bypass level
   int                             mismatches;    // failed comparisons
   int                             nChecks;       // comparisons made
   int                             cycles;        // timeout counter

   mcr_modem_config DUT (
      .mclk         (mclk),
      .rst          (rst),
      .regReq       (regReq),
      .regRdata     (regRdata),
      .regRvalid    (regRvalid),
      .sampleIn     (sampleIn),
      .sampleValid  (sampleValid),
      .dcOut        (dcOut),
      .dcValid      (dcValid),
      .decimStrobe  (decimStrobe),
      .symbolStrobe (symbolStrobe),
      .modulation   (modulation),
      .dcBypass     (dcBypass)
   );

   // ==========================================================
   // clock and hang guard
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // a hang is cut short well past the expected run length
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // one-cycle write strobe, then one idle edge before the next request
   task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
      regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      #1;
      regReq = '0;
      @(posedge mclk);
      #1;
   endtask : reg_write

   // one-cycle read strobe, answer taken the cycle after
   task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
      regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      #1;
      regReq = '0;
      `CHK(regRvalid, 1'b1)
      d = regRdata;
      @(posedge mclk);
      #1;
   endtask : reg_read

   // find a strobe, then count cycles to the next one
   task automatic strobe_gap(input bit sym, output int gap);
      gap = 0;
      while (((sym ? symbolStrobe : decimStrobe) !== 1'b1) && gap < 3000)
      begin
         @(posedge mclk);
         #1;
         gap++;
      end
      gap = 0;
      do
      begin
         @(posedge mclk);
         #1;
         gap++;
      end while (((sym ? symbolStrobe : decimStrobe) !== 1'b1) && gap < 3000);
   endtask : strobe_gap

   // one sample in, its filtered value out
   task automatic send_sample(input logic signed [11:0] s, output logic signed [12:0] o);
      sampleIn    = s;
      sampleValid = 1'b1;
      @(posedge mclk);
      #1;
      sampleValid = 1'b0;
      `CHK(dcValid, 1'b1)
      o = dcOut;
      @(posedge mclk);
      #1;
   endtask : send_sample

   // ==========================================================
   // scenarios
   task automatic test_reset_values();
      logic [7:0] d;
      reg_read(MCR_ADDR_BW_EXP, d);
      `CHK(d, 8'h8C)
      reg_read(MCR_ADDR_RATE_MANT, d);
      `CHK(d, 8'h22)
      reg_read(MCR_ADDR_FMT_CTRL, d);
      `CHK(d[7:4], 4'h0)
      reg_read(6'h13, d);
      `CHK(d, 8'h00)
   endtask : test_reset_values

   // default ratio 8 * 4 * 2^2 and two rewritten ratios
   task automatic test_decim();
      int g;
      logic [7:0] cfg [2] = '{8'h3C, 8'hFC};
      int         exp [2] = '{56, 448};
      strobe_gap(1'b0, g);
      `CHK(g, 128)
      for (int i = 0; i < 2; i++)
      begin
         reg_write(MCR_ADDR_BW_EXP, cfg[i]);
         strobe_gap(1'b0, g);
         strobe_gap(1'b0, g);
         `CHK(g, exp[i])
      end
   endtask : test_decim

   // dc estimate follows the input, bypass passes it untouched
   task automatic test_dc_filter();
      logic signed [12:0] o;
      send_sample(12'sh100, o);
      `CHK(o, 13'sh0100)
      send_sample(12'sh100, o);
      `CHK(o, 13'sh00F0)
      // rate exponent 10 with mantissa 34 gives about 138 kBaud, low enough for bypass
      reg_write(MCR_ADDR_BW_EXP, 8'h8A);
      // intermediate frequency is retuned outside this block before bypassing
      reg_write(MCR_ADDR_FMT_CTRL, 8'h80);
      @(posedge mclk);
      #1;
      `CHK(dcBypass, 1'b1)
      send_sample(12'sh100, o);
      `CHK(o, 13'sh0100)
      send_sample(-12'sh050, o);
      `CHK(o, -13'sh0050)
   endtask : test_dc_filter

   // every modulation code, including the unassigned ones
   task automatic test_modulation();
      logic [7:0] d;
      mcr_mod_t   exp [8] = '{MCR_MOD_FSK2, MCR_MOD_GFSK, MCR_MOD_NONE, MCR_MOD_ASK,
                              MCR_MOD_NONE, MCR_MOD_NONE, MCR_MOD_NONE, MCR_MOD_MSK};
      for (int c = 0; c < 8; c++)
      begin
         reg_write(MCR_ADDR_FMT_CTRL, {1'b0, c[2:0], 4'h5});
         @(posedge mclk);
         #1;
         `CHK(modulation, exp[c])
         `CHK(dcBypass, 1'b0)
         reg_read(MCR_ADDR_FMT_CTRL, d);
         `CHK(d, {1'b0, c[2:0], 4'h5})
      end
   endtask : test_modulation

   // hidden one gives step 2^23, then a fractional mean period
   task automatic test_symbol();
      int g;
      int n;
      reg_write(MCR_ADDR_BW_EXP, 8'h0F);
      reg_write(MCR_ADDR_RATE_MANT, 8'h00);
      strobe_gap(1'b1, g);
      strobe_gap(1'b1, g);
      `CHK(g, 32)
      reg_write(MCR_ADDR_RATE_MANT, 8'hFF);
      strobe_gap(1'b1, g);
      n = 0;
      for (int i = 0; i < 2048; i++)
      begin
         @(posedge mclk);
         #1;
         if (symbolStrobe === 1'b1)
            n++;
      end
      `CHK(n inside {127, 128}, 1'b1)
      strobe_gap(1'b1, g);
      `CHK(g inside {16, 17}, 1'b1)
   endtask : test_symbol

   // ==========================================================
   // main sequence
   initial
   begin
      mismatches  = 0;
      nChecks     = 0;
      cycles      = 0;
      rst         = 1'b1;
      regReq      = '0;
      sampleIn    = '0;
      sampleValid = 1'b0;
      repeat (10) @(posedge mclk);
      #1;
      rst = 1'b0;
      test_reset_values();
      test_dc_filter();
      test_modulation();
      test_decim();
      test_symbol();
      report_and_stop();
   end

endmodule : mcr_modem_config_bench
